// File: hdl/sarh_pkg.sv
// Package with constants and carrier types for the converter result handshake.
//
// Contract
// - Busy low from conversion start to end.
// - Result driven shortly before busy rises.
// - Result is 16-bit signed two's complement.
// - One code step equals 76 microvolts.
// - Outputs drive only outside conversion, during acquisition; the code also drives them in the last DV_N cycles before busy rises.
// - Switch closed in acquisition, opens to hold.
// - Convert on chip select fall; read otherwise; the code also converts while chip select is held low with rd_conv low.
// - Outputs high impedance during conversion.
package sarh_pkg;
  localparam int          CLK_PERIOD_PS  = 5000;
  localparam int          CONV_TIME_PS   = 3400000;
  localparam int          CONV_CYCLES    = CONV_TIME_PS / CLK_PERIOD_PS;
  localparam int          DVALID_TIME_PS = 25000;
  localparam int          DVALID_CYCLES  = (DVALID_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          LSB_UV         = 76;
  localparam int          RES_W          = 16;
  localparam logic [15:0] CODE_POS_FULL  = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FULL  = 16'h8000;
  localparam logic [15:0] CODE_RESET     = 16'h0000;
  localparam int          FIFO_DEPTH     = 16;

  typedef enum logic [1:0] {
    SARH_ACQ   = 2'b00,
    SARH_CONV  = 2'b01,
    SARH_DRIVE = 2'b10
  } sarh_state_t;

  typedef struct packed {
    logic [15:0] data;
    logic        oe;
  } sarh_bus_t;
endpackage

// File: hdl/sarh_fifo.sv
// Result FIFO and the converter result handshake top.
`timescale 1ns/100ps
module sarh_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // The fill level may never pass the depth, or the pointers would wrap onto live words.
  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n)
      cnt_reg <= DEPTH[AW:0];
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo level past depth");

  property p_fifo_full_valid;
    @(posedge clk) disable iff (!rst_n)
      !in_ready |-> out_valid;
  endproperty
  a_fifo_full_valid: assert property (p_fifo_full_valid) else $error("full but empty");

  property p_fifo_empty_ready;
    @(posedge clk) disable iff (!rst_n)
      !out_valid |-> in_ready;
  endproperty
  a_fifo_empty_ready: assert property (p_fifo_empty_ready) else $error("empty but full");
endmodule // sarh_fifo

module sarh_top #(
  parameter int CONV_N = sarh_pkg::CONV_CYCLES,
  parameter int DV_N   = sarh_pkg::DVALID_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Control pins, asynchronous
  input  wire logic                   cs_n,
  input  wire logic                   rd_conv,
  // Converter core: digitised held sample
  input  wire logic [sarh_pkg::RES_W-1:0] core_code,
  // Status and sampling switch
  output logic                        busy_n,
  output logic                        sample_closed,
  // Parallel result pins
  output logic [sarh_pkg::RES_W-1:0]  result_bus_o,
  output logic [sarh_pkg::RES_W-1:0]  result_bus_oe,
  // Buffered result stream
  output logic                        res_valid,
  input  wire logic                   res_ready,
  output logic [sarh_pkg::RES_W-1:0]  res_data,
  output logic                        res_overrun
);
  import sarh_pkg::*;

  logic        cs_m_reg, cs_s_reg, cs_d_reg, rc_m_reg, rc_s_reg;
  sarh_state_t st_reg, st_next;
  logic [15:0] cnt_reg;
  logic [15:0] res_reg;
  logic        busy_reg, samp_reg, ovr_reg;
  sarh_bus_t   bus_reg;
  logic        f_ready;
  // Helper for the checks: cycles in a row that busy has been seen low.
  logic [15:0] busy_len_reg;

  always_ff @(posedge clk) begin
    cs_m_reg <= cs_n;
    cs_s_reg <= cs_m_reg;
    cs_d_reg <= cs_s_reg;
    rc_m_reg <= rd_conv;
    rc_s_reg <= rc_m_reg;
  end

  // A select held low after busy rises is taken as a start even without a new fall, so that case restarts.
  wire cs_fall  = cs_d_reg && !cs_s_reg;
  wire start    = (st_reg == SARH_ACQ) && !rc_s_reg && (cs_fall || !cs_s_reg);
  wire cnt_done = (cnt_reg == 16'(CONV_N - 1));
  wire drv_at   = (cnt_reg == 16'(CONV_N - 1 - DV_N));
  wire read_en  = (st_reg == SARH_ACQ) && rc_s_reg && !cs_s_reg;
  wire push_res = (st_reg == SARH_DRIVE) && cnt_done;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      SARH_ACQ:   if (start) st_next = SARH_CONV;
      SARH_CONV:  if (drv_at) st_next = SARH_DRIVE;
      SARH_DRIVE: if (cnt_done) st_next = SARH_ACQ;
      default:    st_next = SARH_ACQ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg   <= SARH_ACQ;
      cnt_reg  <= '0;
      busy_reg <= 1'b1;
      samp_reg <= 1'b1;
      res_reg  <= CODE_RESET;
      ovr_reg  <= 1'b0;
      bus_reg  <= '0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= (st_reg == SARH_ACQ) ? '0 : cnt_reg + 16'h0001;
      busy_reg <= !(st_next != SARH_ACQ);
      samp_reg <= (st_next == SARH_ACQ);
      if (st_reg == SARH_CONV && drv_at) res_reg <= core_code;
      if (st_reg == SARH_DRIVE && cnt_done && !f_ready) ovr_reg <= 1'b1;
      bus_reg.oe   <= (st_next == SARH_DRIVE) || (st_next == SARH_ACQ && read_en);
      bus_reg.data <= (st_reg == SARH_CONV && drv_at) ? core_code : res_reg;
    end
  end

  assign busy_n        = busy_reg;
  assign sample_closed = samp_reg;
  assign result_bus_o  = bus_reg.data;
  assign result_bus_oe = {RES_W{bus_reg.oe}};
  assign res_overrun   = ovr_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_len_reg <= '0;
    end else begin
      busy_len_reg <= busy_n ? 16'h0000 : busy_len_reg + 16'h0001;
    end
  end

  // Each finished result enters the FIFO as busy rises unless it is full (then res_overrun is set), isolating the pins from the host.
  sarh_fifo #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push_res),
    .in_ready  (f_ready),
    .in_data   (res_reg),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  property p_busy_hold;
    @(posedge clk) disable iff (!rst_n)
      $fell(busy_n) |-> !busy_n [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy low too short");

  property p_data_before_busy;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> $past(bus_reg.oe, 2) && $past(bus_reg.oe, 1);
  endproperty
  a_data_before_busy: assert property (p_data_before_busy) else $error("data late");

  property p_no_drive_early;
    @(posedge clk) disable iff (!rst_n)
      $fell(busy_n) |-> !bus_reg.oe [*8];
  endproperty
  a_no_drive_early: assert property (p_no_drive_early) else $error("bus driven in conv");

  property p_switch;
    @(posedge clk) disable iff (!rst_n)
      sample_closed == busy_n;
  endproperty
  a_switch: assert property (p_switch) else $error("switch mismatch");

  property p_oe_in_conv;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == SARH_CONV && !$rose(st_reg == SARH_CONV)) |-> !bus_reg.oe;
  endproperty
  a_oe_in_conv: assert property (p_oe_in_conv) else $error("drive in conversion");

  property p_return_acq;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> st_reg == SARH_ACQ && sample_closed;
  endproperty
  a_return_acq: assert property (p_return_acq) else $error("not back in acquisition");

  property p_conv_len;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> busy_len_reg == 16'(CONV_N);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion ended early");

  property p_result_stable;
    @(posedge clk) disable iff (!rst_n)
      $rose(busy_n) |-> result_bus_o == res_reg;
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("bad result word");

  sequence s_busy_rise;
    $rose(busy_n);
  endsequence

  sequence s_conv_begin;
    start ##1 (!busy_n && !sample_closed);
  endsequence

  property p_start_conv;
    @(posedge clk) disable iff (!rst_n)
      s_conv_begin |=> !busy_n [*8];
  endproperty
  a_start_conv: assert property (p_start_conv) else $error("start not held");

  property p_read_drive;
    @(posedge clk) disable iff (!rst_n)
      read_en |=> bus_reg.oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");

  // A second start while converting must not cut the conversion short.
  property p_conv_no_restart;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == SARH_CONV) |=> (st_reg != SARH_ACQ);
  endproperty
  a_conv_no_restart: assert property (p_conv_no_restart) else $error("conv cut");

  property p_oe_state;
    @(posedge clk) disable iff (!rst_n)
      bus_reg.oe |-> (st_reg != SARH_CONV);
  endproperty
  a_oe_state: assert property (p_oe_state) else $error("pins driven too early");

  property p_overrun_sticky;
    @(posedge clk) disable iff (!rst_n)
      res_overrun |=> res_overrun;
  endproperty
  a_overrun_sticky: assert property (p_overrun_sticky) else $error("overrun lost");

  property p_overrun_set;
    @(posedge clk) disable iff (!rst_n)
      (push_res && !f_ready) |=> res_overrun;
  endproperty
  a_overrun_set: assert property (p_overrun_set) else $error("drop not flagged");

  // The word must enter the buffer on the same edge that releases busy.
  property p_push_at_rise;
    @(posedge clk) disable iff (!rst_n)
      push_res |=> s_busy_rise;
  endproperty
  a_push_at_rise: assert property (p_push_at_rise) else $error("push off busy edge");

  property p_switch_state;
    @(posedge clk) disable iff (!rst_n)
      sample_closed == (st_reg == SARH_ACQ);
  endproperty
  a_switch_state: assert property (p_switch_state) else $error("switch off state");

  property p_idle_busy;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == SARH_ACQ) |-> busy_n;
  endproperty
  a_idle_busy: assert property (p_idle_busy) else $error("busy low in acquisition");

  property p_data_hold;
    @(posedge clk) disable iff (!rst_n)
      (st_reg == SARH_DRIVE && $past(st_reg) == SARH_DRIVE) |-> $stable(bus_reg.data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("result moved while driven");
endmodule // sarh_top

// File: test/sarh_latch.sv
// Output latch model that takes the result word on the rising edge of busy.
`timescale 1ns/100ps
module sarh_latch (
  // Pins of the converter
  input  wire logic        clk,
  input  wire logic        busy_n,
  input  wire logic [15:0] bus_o,
  input  wire logic [15:0] bus_oe,
  // Captured word
  output logic      [15:0] word,
  output logic             bad_oe
);
  logic        busy_q;
  logic [15:0] bus_q;
  logic [15:0] oe_q;
  // The word is taken from the cycle just before busy rose, so it must already be driven then.
  always_ff @(posedge clk) begin
    busy_q <= busy_n;
    bus_q  <= bus_o;
    oe_q   <= bus_oe;
    if (busy_n && !busy_q) begin
      word   <= bus_q;
      bad_oe <= (oe_q !== 16'hFFFF);
    end
  end
endmodule // sarh_latch

// File: test/sar_adc_result_handshake_tb_top.sv
// Testbench for the converter result handshake with its result FIFO.
`timescale 1ns/100ps
module sar_adc_result_handshake_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n = 1'b1;
  logic        rd_conv = 1'b1;
  logic        res_ready = 1'b0;
  logic [15:0] core_code = 16'h0000;
  logic        busy_n, sample_closed, res_valid, res_overrun, bad_oe;
  logic [15:0] bus_o, bus_oe, res_data, word;
  logic [15:0] exp_q[$];
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #2.5 clk = ~clk;
  sarh_top #(.CONV_N(20), .DV_N(3)) DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .rd_conv(rd_conv), .core_code(core_code), .busy_n(busy_n),
    .sample_closed(sample_closed), .result_bus_o(bus_o), .result_bus_oe(bus_oe),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
    .res_overrun(res_overrun));
  sarh_latch latch (.clk(clk), .busy_n(busy_n), .bus_o(bus_o), .bus_oe(bus_oe),
    .word(word), .bad_oe(bad_oe));
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One conversion; a second start in mid-conversion must be ignored.
  task automatic conv(input logic [15:0] code);
    int n;
    core_code = code;
    rd_conv = 1'b0;
    step(20);
    cs_n = 1'b0;
    n = 0;
    while (busy_n !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    cs_n = 1'b1;
    check("sample_closed", sample_closed, 1'b0);
    check("oe_in_conv", bus_oe, 16'h0000);
    n = 1;
    while (busy_n === 1'b0 && n < 100) begin
      if (n == 6) cs_n = 1'b0;
      if (n == 8) cs_n = 1'b1;
      if (n == 10) rd_conv = 1'b1;
      step(1);
      n++;
    end
    check("busy_low_len", n - 1, 20);
    step(2);
    check("latched", word, code);
    check("oe_at_busy", bad_oe, 1'b0);
    check("closed_after", sample_closed, 1'b1);
    step(4);
  endtask
  // Seventeen results with the drain stalled: the last one is dropped.
  task automatic fill_and_drain;
    logic [15:0] c;
    for (int i = 0; i < 17; i++) begin
      c = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h0000 : (i == 2) ? 16'hFFFF :
          (i == 3) ? 16'h8000 : 16'h0101 * i[15:0];
      if (i < 16) exp_q.push_back(c);
      conv(c);
    end
    check("overrun", res_overrun, 1'b1);
    res_ready = 1'b1;
    for (int i = 0; i < 16; i++) begin
      check("res_valid", res_valid, 1'b1);
      check("res_data", res_data, exp_q[i]);
      step(1);
    end
    check("empty", res_valid, 1'b0);
  endtask
  // Read mode outside a conversion drives the last result onto the pins.
  task automatic read_back(input logic [15:0] code);
    rd_conv = 1'b1;
    cs_n = 1'b0;
    step(4);
    check("read_oe", bus_oe, 16'hFFFF);
    check("read_data", bus_o, code);
    check("read_busy", busy_n, 1'b1);
    cs_n = 1'b1;
    step(4);
    check("read_release", bus_oe, 16'h0000);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish;
    end
  end
  initial begin
    step(10);
    rst_n = 1'b1;
    step(4);
    check("idle_busy", busy_n, 1'b1);
    fill_and_drain;
    read_back(16'h1010);
    tally_and_finish;
  end
endmodule // sar_adc_result_handshake_tb_top
